/* dv/serial_host.sv */
/*
  Serial host model: sends 24-bit programming words on the three pins.
  Assumes the device samples data on sclk rise while the strobe is low.
*/
`timescale 1ns/1ps
module serial_host
  import synth_load_pkg::*;
(
  output synth_load_pkg::serial_pins_t pins
);
  import synth_load_pkg::*;

  initial begin
    pins = '{sclk: 1'b0, sdata: 1'b0, strobe: 1'b1};
  end

  ////////////////////////////////////////////////////////////////
  // 80 ns bit period, clock idle low between frames
  task automatic send(input logic [WORD_W-1:0] w);
    pins.strobe = 1'b0;
    #40;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      pins.sdata = w[i];
      #20 pins.sclk = 1'b1;
      #40 pins.sclk = 1'b0;
      #20;
    end
    pins.sdata = ~pins.sdata;
    pins.strobe = 1'b1;
    #40;
  endtask
endmodule

/* dv/test_synth_serial_port.sv */
/*
  Self-checking bench for the programming port and realignment timer.
  Assumes the serial host model on the pins; this module is Wishbone master.
*/
`timescale 1ns/1ps
module test_synth_serial_port;
  import synth_load_pkg::*;
  typedef struct packed {logic [WORD_W-1:0] word; logic [7:0] adr;} row_t;
  logic core_clk, rstn, cmp_clk, cyc, stb, we, ack, realign, syncp, loaded;
  logic [7:0] adr;
  logic [31:0] rdat, dout;
  logic [MULT_W-1:0] mult;
  logic [MOD_W-1:0] modv, base;
  serial_pins_t pins;
  int bad_count = 0;
  int tests_run = 0;
  int syncs = 0;
  int n;
  // Modulus 4 then base 8 (a multiple of it); control sets multiplier 1
  row_t rows[5] = '{'{24'h000010, 8'h00}, '{24'h800020, 8'h00}, '{24'h000001, 8'h04},
    '{24'h001002, 8'h08}, '{24'h000003, 8'h0c}};

  synth_serial_port synth_serial_port_i (.core_clk(core_clk), .rstn(rstn), .pins(pins), .cmp_clk(cmp_clk),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(32'h0),
    .wb_dat_o(dout), .wb_ack_o(ack), .realign_pulse(realign), .sync_pulse_o(syncp), .resync_mult(mult),
    .fraction_modulus(modv), .resync_base(base), .word_loaded(loaded));
  serial_host serial_host_i (.pins(pins));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    cmp_clk = 1'b0;
    #1.3;
    forever #20 cmp_clk = ~cmp_clk;
  end
  always @(posedge core_clk) begin
    if (loaded) syncs <= 0;
    else if (syncp) syncs <= syncs + 1;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wb_read(input logic [7:0] a, output logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b0;
    adr <= a;
    do begin
      @(posedge core_clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    d = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50) chk("wb ack", 32'h1, 32'h0);
    @(posedge core_clk);
  endtask
  task automatic wait_on(input bit want_realign, output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while ((want_realign ? realign : syncp) !== 1'b1 && c < 400);
    if (c >= 400) chk("pulse wait", 32'h1, 32'h0);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    chk("modulus reset", 32'h2, {20'h0, modv});
    chk("base reset", 32'h0, {20'h0, base});
    chk("mult reset", 32'h0, {28'h0, mult});
    repeat (4) @(posedge core_clk);
    chk("modulus after release", 32'h2, {20'h0, modv});
    foreach (rows[i]) begin
      serial_host_i.send(rows[i].word);
      @(posedge core_clk);
      wb_read(rows[i].adr, rdat);
      chk("latch", {8'h00, rows[i].word}, rdat);
      $display("row %0d done", i);
    end
    chk("modulus kept", 32'h4, {20'h0, modv});
    chk("base", 32'h8, {20'h0, base});
    chk("mult", 32'h1, {28'h0, mult});
    wb_read(8'h20, rdat);
    chk("unmapped", 32'h0, rdat);
    wb_read(ADR_STATUS_FULL, rdat);
    chk("status", 32'h00008004, rdat);
    $display("map test done");
    wait_on(1'b0, n);
    wait_on(1'b0, n);
    chk("sync period", 32'd80, n);
    @(posedge core_clk);
    chk("sync width", 32'h0, {31'h0, syncp});
    $display("timer test done");
    serial_host_i.send(24'h000010);
    wait_on(1'b1, n);
    chk("syncs before realign", 32'd2, syncs);
    $display("realign test done");
    serial_host_i.send(24'h000002);
    @(posedge core_clk);
    n = 0;
    repeat (200) begin
      @(posedge core_clk);
      if (syncp === 1'b1 || realign === 1'b1) n++;
    end
    chk("disabled pulses", 32'h0, n);
    $display("disable test done");
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    chk("modulus rereset", 32'h2, {20'h0, modv});
    repeat (4) @(posedge core_clk);
    chk("modulus after rerelease", 32'h2, {20'h0, modv});
    wb_read(ADR_SYNCCNT, rdat);
    chk("sync count reset", 32'h0, rdat);
    $display("reset test done");
    summarize();
  end
endmodule

/* hdl/pin_sync.sv */
/*
  Two-stage synchroniser for the serial pins, with rising-edge detect
  taken only from the second stage and one more history stage.
  Assumes pins are asynchronous to core_clk.
*/
`timescale 1ns/1ps
module pin_sync
  import synth_load_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input synth_load_pkg::serial_pins_t pins,
  output synth_load_pkg::serial_pins_t level,
  output synth_load_pkg::serial_pins_t rise
);
  typedef struct packed {
    serial_pins_t s1;
    serial_pins_t s2;
    serial_pins_t s3;
  } sync_state_t;
  sync_state_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // Idle strobe high, so no false load edge after reset
      st_q <= '{s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE};
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.s2;
  assign rise = st_q.s2 & ~st_q.s3;
endmodule

/* hdl/realign_timer.sv */
/*
  Realignment timer counting comparison-clock edges; wraps at
  multiplier*base and pulses once per wrap.
  Assumes cmp_tick is a one-cycle pulse per comparison period.
*/
`timescale 1ns/1ps
module realign_timer
  import synth_load_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cmp_tick,
  input wire logic [synth_load_pkg::MULT_W-1:0] mult,
  input wire logic [synth_load_pkg::MOD_W-1:0] base,
  output logic sync_pulse
);
  typedef struct packed {
    logic [TIMER_W-1:0] cnt;
    logic pulse;
  } tmr_state_t;
  tmr_state_t st_q, st_d;
  logic [TIMER_W-1:0] limit;

  assign limit = TIMER_W'(mult) * TIMER_W'(base);

  always_comb begin
    st_d = st_q;
    st_d.pulse = 1'b0;
    if (mult == '0 || limit == '0) begin
      st_d.cnt = '0;
    end else if (cmp_tick) begin
      if (st_q.cnt + 16'h0001 >= limit) begin
        st_d.cnt = '0;
        st_d.pulse = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_pulse = st_q.pulse;

  AST_DISABLED_NO_PULSE: assert property (@(posedge core_clk) disable iff (!rstn)
    (mult == '0) |=> !sync_pulse)
    else $error("pulse while disabled");
  AST_PULSE_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (!rstn)
    sync_pulse |=> !sync_pulse)
    else $error("pulse longer than one cycle");
  AST_PULSE_NEEDS_TICK: assert property (@(posedge core_clk) disable iff (!rstn)
    sync_pulse |-> $past(cmp_tick))
    else $error("pulse without comparison tick");
endmodule

/* hdl/synth_load_pkg.sv */
/*
  Constants and carriers for the three-wire programming port and the
  phase realignment timer.
  Assumes a single core clock domain; serial pins arrive asynchronously.
*/
package synth_load_pkg;
  localparam int WORD_W = 24;
  localparam int SEL_W = 2;
  localparam logic [1:0] SEL_DIVIDER = 2'h0;
  localparam logic [1:0] SEL_REFDIV = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_NOISE = 2'h3;
  localparam int LOADCTL_BIT = 23;
  localparam int MOD_LSB = 2;
  localparam int MOD_W = 12;
  localparam int MULT_LSB = 12;
  localparam int MULT_W = 4;
  localparam int TIMER_W = MULT_W + MOD_W;
  localparam logic [MOD_W-1:0] MOD_RESET = 12'h002;
  localparam logic [MOD_W-1:0] BASE_RESET = 12'h000;
  localparam logic [MULT_W-1:0] MULT_RESET = 4'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
  // Wishbone register offsets
  localparam logic [3:0] ADR_DIVIDER = 4'h0;
  localparam logic [3:0] ADR_REFDIV = 4'h4;
  localparam logic [3:0] ADR_CONTROL = 4'h8;
  localparam logic [3:0] ADR_NOISE = 4'hc;
  localparam logic [3:0] ADR_STATUS = 4'h0 + 4'h0;
  localparam logic [7:0] ADR_STATUS_FULL = 8'h10;
  localparam logic [7:0] ADR_SYNCCNT = 8'h14;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic strobe;
  } serial_pins_t;
  // Pin levels while the host is idle
  localparam serial_pins_t PINS_IDLE = '{sclk: 1'b0, sdata: 1'b0, strobe: 1'b1};

  typedef struct packed {
    logic [WORD_W-1:0] divider_word;
    logic [WORD_W-1:0] refdiv_word;
    logic [WORD_W-1:0] control_word;
    logic [WORD_W-1:0] noise_word;
  } latches_t;
endpackage

/* hdl/synth_serial_port.sv */
/*
  Three-wire programming port with four latches, a Wishbone slave that
  reads the latches and timer state, and the realignment controller.
  Assumes serial pins and the comparison clock are asynchronous inputs.
*/
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module synth_serial_port
  import synth_load_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input synth_load_pkg::serial_pins_t pins,
  input wire logic cmp_clk,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic realign_pulse,
  output logic sync_pulse_o,
  output logic [synth_load_pkg::MULT_W-1:0] resync_mult,
  output logic [synth_load_pkg::MOD_W-1:0] fraction_modulus,
  output logic [synth_load_pkg::MOD_W-1:0] resync_base,
  output logic word_loaded
);
  import synth_load_pkg::*;

  ////////////////////////////////////////////////////////////////////
  typedef enum {ARM_IDLE, ARM_WAIT1, ARM_WAIT2} arm_t;

  typedef struct packed {
    logic [WORD_W-1:0] shift;
    latches_t lat;
    logic [MOD_W-1:0] modulus;
    logic [MOD_W-1:0] base;
    logic [2:0] cmp_hist;
    arm_t arm;
    logic realign;
    logic sync_seen;
    logic loaded;
    logic [15:0] sync_count;
    logic ack;
    logic [31:0] rdata;
  } port_state_t;
  port_state_t st_q, st_d;

  serial_pins_t pin_lvl, pin_rise;
  logic cmp_tick;
  logic sync_pulse;
  logic wb_req;

  ////////////////////////////////////////////////////////////////////
  pin_sync u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pins(pins),
    .level(pin_lvl),
    .rise(pin_rise)
  );

  // Comparison clock: two-flop sync in cmp_hist[1:0], edge from [2:1]
  assign cmp_tick = st_q.cmp_hist[1] & ~st_q.cmp_hist[2];

  realign_timer u_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .cmp_tick(cmp_tick),
    .mult(st_q.lat.control_word[MULT_LSB +: MULT_W]),
    .base(st_q.base),
    .sync_pulse(sync_pulse)
  );

  assign wb_req = wb_cyc_i & wb_stb_i & ~st_q.ack;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.realign = 1'b0;
    st_d.loaded = 1'b0;
    st_d.sync_seen = sync_pulse;
    st_d.cmp_hist = {st_q.cmp_hist[1:0], cmp_clk};
    st_d.ack = 1'b0;

    // Shift only while strobe low
    if (pin_rise.sclk && !pin_lvl.strobe) begin
      st_d.shift = {st_q.shift[WORD_W-2:0], pin_lvl.sdata};
    end

    if (pin_rise.strobe) begin
      st_d.loaded = 1'b1;
      case (st_q.shift[SEL_W-1:0])
        SEL_DIVIDER: begin
          st_d.lat.divider_word = st_q.shift;
          if (st_q.shift[LOADCTL_BIT]) begin
            st_d.base = st_q.shift[MOD_LSB +: MOD_W];
          end else begin
            st_d.modulus = st_q.shift[MOD_LSB +: MOD_W];
            st_d.arm = ARM_WAIT1;
          end
        end
        SEL_REFDIV: st_d.lat.refdiv_word = st_q.shift;
        SEL_CONTROL: st_d.lat.control_word = st_q.shift;
        SEL_NOISE: st_d.lat.noise_word = st_q.shift;
        default: st_d.lat.noise_word = st_q.shift;
      endcase
    end else if (st_q.sync_seen) begin
      st_d.sync_count = st_q.sync_count + 16'h0001;
      case (st_q.arm)
        ARM_WAIT1: st_d.arm = ARM_WAIT2;
        ARM_WAIT2: begin
          st_d.arm = ARM_IDLE;
          st_d.realign = 1'b1;
        end
        default: st_d.arm = ARM_IDLE;
      endcase
    end

    if (st_q.lat.control_word[MULT_LSB +: MULT_W] == MULT_RESET) begin
      st_d.arm = ARM_IDLE;
      st_d.realign = 1'b0;
    end

    // Wishbone: single-cycle ack, registers read-only
    if (wb_req) begin
      st_d.ack = 1'b1;
      case (wb_adr_i)
        {4'h0, ADR_DIVIDER}: st_d.rdata = {8'h00, st_q.lat.divider_word};
        {4'h0, ADR_REFDIV}: st_d.rdata = {8'h00, st_q.lat.refdiv_word};
        {4'h0, ADR_CONTROL}: st_d.rdata = {8'h00, st_q.lat.control_word};
        {4'h0, ADR_NOISE}: st_d.rdata = {8'h00, st_q.lat.noise_word};
        ADR_STATUS_FULL: st_d.rdata = {6'h00, st_q.arm == ARM_IDLE ? 2'h0 :
                                       (st_q.arm == ARM_WAIT1 ? 2'h1 : 2'h2),
                                       st_q.base, st_q.modulus};
        ADR_SYNCCNT: st_d.rdata = {16'h0000, st_q.sync_count};
        default: st_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q.shift <= WORD_RESET;
      st_q.lat <= '0;
      st_q.modulus <= MOD_RESET;
      st_q.base <= BASE_RESET;
      st_q.cmp_hist <= 3'h0;
      st_q.arm <= ARM_IDLE;
      st_q.realign <= 1'b0;
      st_q.sync_seen <= 1'b0;
      st_q.loaded <= 1'b0;
      st_q.sync_count <= 16'h0000;
      st_q.ack <= 1'b0;
      st_q.rdata <= 32'h00000000;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_dat_o = st_q.rdata;
  assign wb_ack_o = st_q.ack;
  assign realign_pulse = st_q.realign;
  assign sync_pulse_o = st_q.sync_seen;
  assign resync_mult = st_q.lat.control_word[MULT_LSB +: MULT_W];
  assign fraction_modulus = st_q.modulus;
  assign resync_base = st_q.base;
  assign word_loaded = st_q.loaded;

  ////////////////////////////////////////////////////////////////////
  // Serial shift register
  AST_SHIFT_IN: assert property (@(posedge core_clk) disable iff (!rstn)
    (pin_rise.sclk && !pin_lvl.strobe) |=> st_q.shift[0] == $past(pin_lvl.sdata))
    else $error("bit not shifted");

  AST_SHIFT_MOVES: assert property (@(posedge core_clk) disable iff (!rstn)
    (pin_rise.sclk && !pin_lvl.strobe) |=> st_q.shift[WORD_W-1:1] == $past(st_q.shift[WORD_W-2:0]))
    else $error("shift register did not move");

  AST_SHIFT_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
    (!pin_rise.sclk) |=> $stable(st_q.shift))
    else $error("shift register moved without serial clock");

  AST_SHIFT_IGNORED: assert property (@(posedge core_clk) disable iff (!rstn)
    (pin_lvl.strobe) |=> $stable(st_q.shift))
    else $error("shift register moved with strobe high");

  // Latch transfer on strobe rise
  AST_DIV_LATCH: assert property (@(posedge core_clk) disable iff (!rstn)
    (pin_rise.strobe && st_q.shift[SEL_W-1:0] == SEL_DIVIDER) |=> st_q.lat.divider_word == $past(st_q.shift))
    else $error("divider word not latched");

  AST_REFDIV_LATCH: assert property (@(posedge core_clk) disable iff (!rstn)
    (pin_rise.strobe && st_q.shift[SEL_W-1:0] == SEL_REFDIV) |=> st_q.lat.refdiv_word == $past(st_q.shift))
    else $error("reference divider word not latched");

  AST_CTRL_LATCH: assert property (@(posedge core_clk) disable iff (!rstn)
    (pin_rise.strobe && st_q.shift[1:0] == SEL_CONTROL) |=> resync_mult == $past(st_q.shift[15:12]))
    else $error("control word not latched");

  AST_NOISE_LATCH: assert property (@(posedge core_clk) disable iff (!rstn)
    (pin_rise.strobe && st_q.shift[SEL_W-1:0] == SEL_NOISE) |=> st_q.lat.noise_word == $past(st_q.shift))
    else $error("noise word not latched");

  AST_LATCH_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
    (!pin_rise.strobe) |=> $stable(st_q.lat))
    else $error("latch changed without strobe");

  AST_LOADED_PULSE: assert property (@(posedge core_clk) disable iff (!rstn)
    pin_rise.strobe |=> word_loaded ##1 !word_loaded)
    else $error("load pulse wrong");

  AST_LOADED_CAUSE: assert property (@(posedge core_clk) disable iff (!rstn)
    word_loaded |-> $past(pin_rise.strobe))
    else $error("load pulse without strobe");

  // Divider word split
  AST_BASE_LOAD: assert property (@(posedge core_clk) disable iff (!rstn)
    (pin_rise.strobe && st_q.shift[1:0] == SEL_DIVIDER && st_q.shift[23])
    |=> resync_base == $past(st_q.shift[13:2]) && $stable(fraction_modulus))
    else $error("base not loaded");

  AST_MOD_LOAD: assert property (@(posedge core_clk) disable iff (!rstn)
    (pin_rise.strobe && st_q.shift[1:0] == SEL_DIVIDER && !st_q.shift[23])
    |=> fraction_modulus == $past(st_q.shift[13:2]) && $stable(resync_base))
    else $error("modulus not loaded");

  AST_DIVIDER_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
    (!pin_rise.strobe) |=> $stable(resync_base) && $stable(fraction_modulus))
    else $error("base or modulus changed without strobe");

  // Realignment arming
  AST_ARM_ON_NEW_FREQ: assert property (@(posedge core_clk) disable iff (!rstn)
    (pin_rise.strobe && st_q.shift[SEL_W-1:0] == SEL_DIVIDER && !st_q.shift[LOADCTL_BIT] && resync_mult != 4'h0)
    |=> st_q.arm == ARM_WAIT1)
    else $error("new frequency did not arm");

  AST_ARM_ADVANCE: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_q.arm == ARM_WAIT1 && sync_pulse_o && !pin_rise.strobe && resync_mult != 4'h0)
    |=> st_q.arm == ARM_WAIT2)
    else $error("first sync did not advance");

  AST_REALIGN_AFTER_SECOND: assert property (@(posedge core_clk) disable iff (!rstn)
    realign_pulse |-> $past(st_q.arm) == ARM_WAIT2 && $past(sync_pulse_o))
    else $error("realign not on second sync");

  AST_REALIGN_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (!rstn)
    realign_pulse |=> !realign_pulse)
    else $error("realign longer than one cycle");

  AST_NO_REALIGN_DISABLED: assert property (@(posedge core_clk) disable iff (!rstn)
    (resync_mult == 4'h0) |-> !realign_pulse)
    else $error("realign while disabled");

  AST_ARM_CLEAR_DISABLED: assert property (@(posedge core_clk) disable iff (!rstn)
    (resync_mult == 4'h0) |=> st_q.arm == ARM_IDLE)
    else $error("armed while disabled");

  AST_REALIGN_NEEDS_ENABLE: assert property (@(posedge core_clk) disable iff (!rstn)
    realign_pulse |-> $past(resync_mult) != 4'h0)
    else $error("realign after disabled cycle");

  // Timer pulse relay and count
  AST_SYNC_OUT_FOLLOWS: assert property (@(posedge core_clk) disable iff (!rstn)
    sync_pulse |=> sync_pulse_o)
    else $error("sync pulse not relayed");

  AST_SYNC_OUT_ONE: assert property (@(posedge core_clk) disable iff (!rstn)
    sync_pulse_o |=> !sync_pulse_o)
    else $error("sync output longer than one cycle");

  AST_SYNC_COUNT_STEP: assert property (@(posedge core_clk) disable iff (!rstn)
    (sync_pulse_o && !pin_rise.strobe) |=> st_q.sync_count == $past(st_q.sync_count) + 16'h0001)
    else $error("sync count did not step");

  // Wishbone read port
  AST_WB_ACK: assert property (@(posedge core_clk) disable iff (!rstn)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("no ack");

  AST_WB_ACK_ONE: assert property (@(posedge core_clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  AST_WB_ACK_CAUSE: assert property (@(posedge core_clk) disable iff (!rstn)
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");

  AST_WB_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
    wb_ack_o |-> wb_dat_o[31:26] == 6'h00)
    else $error("read data upper bits not zero");

  AST_WB_MISALIGNED_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
    (wb_req && wb_adr_i[1:0] != 2'h0) |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");

  AST_WB_DIV_READ: assert property (@(posedge core_clk) disable iff (!rstn)
    (wb_req && wb_adr_i == {4'h0, ADR_DIVIDER}) |=> wb_dat_o == {8'h00, $past(st_q.lat.divider_word)})
    else $error("divider read wrong");

  AST_WB_STATUS_READ: assert property (@(posedge core_clk) disable iff (!rstn)
    (wb_req && wb_adr_i == ADR_STATUS_FULL) |=> wb_dat_o[23:0] == {$past(resync_base), $past(fraction_modulus)})
    else $error("status read wrong");

  AST_WB_SYNCCNT_READ: assert property (@(posedge core_clk) disable iff (!rstn)
    (wb_req && wb_adr_i == ADR_SYNCCNT) |=> wb_dat_o == {16'h0000, $past(st_q.sync_count)})
    else $error("sync count read wrong");
endmodule
